// ==== design/lsu_pkg.sv ====
// shared constants and types for the load-store unit
package lsu_pkg;
  localparam int PIPES           = 3;
  localparam int LQ_DEPTH        = 72;
  localparam int SQ_DEPTH        = 64;
  localparam int SQ_IDX_W        = 6;
  localparam int MAB_DEPTH       = 24;
  localparam int MAX_WIDE_LOADS  = 2;
  localparam int MAX_STORES      = 2;
  localparam int ADDR_W          = 48;
  localparam int FWD_BITS        = 12;
  localparam int LINE_LSB        = 6;
  localparam int LINE_W          = ADDR_W - LINE_LSB;
  localparam int DATA_W          = 256;
  localparam int SZ_W            = 6;
  localparam int IP_W            = 8;
  localparam int LAT_W           = 4;
  localparam logic [LAT_W-1:0] LAT_INT_SIMPLE = 4'h4;
  localparam logic [LAT_W-1:0] LAT_FP_SIMPLE  = 4'h7;
  localparam logic [LAT_W-1:0] LAT_EXTRA      = 4'h1;
  localparam int PF_NUM          = 5;
  localparam int PF_L1_STREAM    = 0;
  localparam int PF_L1_STRIDE    = 1;
  localparam int PF_L1_REGION    = 2;
  localparam int PF_L2_STREAM    = 3;
  localparam int PF_L2_UPDOWN    = 4;
  localparam int PF_TBL_W        = 4;
  localparam int PF_RG_W         = 4;
  localparam logic [LINE_W-1:0] PF_L2_AHEAD = 42'h2;

  typedef struct packed {
    logic                valid;
    logic                is_store;
    logic                wide;
    logic                fp;
    logic                complex;
    logic                seg_nz;
    logic [IP_W-1:0]     ip;
    logic [SQ_IDX_W-1:0] sq_idx;
    logic [SZ_W-1:0]     size;
    logic [ADDR_W-1:0]   addr;
  } mem_op_type;

  typedef struct packed {
    logic              valid;
    logic              addr_ok;
    logic              data_ok;
    logic [SZ_W-1:0]   size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sq_entry_type;

  typedef struct packed {
    logic              valid;
    logic [SZ_W-1:0]   size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dc_write_type;

  typedef struct packed {
    logic              valid;
    logic              to_l1;
    logic [LINE_W-1:0] line;
  } pf_req_type;
endpackage

// ==== design/data_prefetcher.sv ====
// l1 and l2 data prefetch engines with individual enables
`timescale 1ns/1ps
`default_nettype none
module data_prefetcher
  import lsu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              trig_valid,
  input  wire logic [IP_W-1:0]   trig_ip,
  input  wire logic [LINE_W-1:0] trig_line,
  input  wire logic [PF_NUM-1:0] pf_enable,
  output pf_req_type             pf_req_r
);
  localparam int TBL = 1 << PF_TBL_W;

  logic [LINE_W-1:0]             last_r, last_nxt;
  logic [PF_TBL_W-1:0]           pip_r, pip_nxt;
  logic                          l2_seen_r, l2_seen_nxt, l2_dir_r, l2_dir_nxt;
  logic [1:0]                    ud_r, ud_nxt;
  logic [TBL-1:0][LINE_W-1:0]    st_line_r, st_line_nxt, st_dist_r, st_dist_nxt;
  logic [TBL-1:0][PF_RG_W-1:0]   rg_d_r, rg_d_nxt;
  logic [TBL-1:0]                rg_ok_r, rg_ok_nxt;
  pf_req_type                    req_nxt;
  logic [LINE_W-1:0]             delta, sdist, rg_ext;
  logic [PF_TBL_W-1:0]           idx;
  logic                          asc, desc, near;

  always_comb begin
    idx         = trig_ip[PF_TBL_W-1:0];
    delta       = trig_line - last_r;
    sdist       = trig_line - st_line_r[idx];
    rg_ext      = {{(LINE_W-PF_RG_W){rg_d_r[idx][PF_RG_W-1]}}, rg_d_r[idx]};
    asc         = delta == 42'h1;
    desc        = &delta;
    near        = (&delta[LINE_W-1:PF_RG_W-1]) | ~(|delta[LINE_W-1:PF_RG_W-1]);
    req_nxt     = '0;
    last_nxt    = last_r;
    pip_nxt     = pip_r;
    l2_seen_nxt = l2_seen_r;
    l2_dir_nxt  = l2_dir_r;
    ud_nxt      = ud_r;
    st_line_nxt = st_line_r;
    st_dist_nxt = st_dist_r;
    rg_d_nxt    = rg_d_r;
    rg_ok_nxt   = rg_ok_r;
    if (trig_valid) begin
      // priority among engines, one request per cycle; l1 engines fill both levels
      if (pf_enable[PF_L1_STREAM] && (asc || desc)) begin // [R15] [R16]
        req_nxt = '{valid: 1'b1, to_l1: 1'b1, line: asc ? trig_line + 42'h1 : trig_line - 42'h1};
      end else if (pf_enable[PF_L1_STRIDE] && sdist == st_dist_r[idx] && |sdist) begin // [R17]
        req_nxt = '{valid: 1'b1, to_l1: 1'b1, line: trig_line + sdist};
      end else if (pf_enable[PF_L1_REGION] && rg_ok_r[idx]) begin // [R18]
        req_nxt = '{valid: 1'b1, to_l1: 1'b1, line: trig_line + rg_ext};
      end else if (pf_enable[PF_L2_STREAM] && l2_seen_r && ((asc && l2_dir_r) ||
                   (desc && !l2_dir_r))) begin // [R19]
        req_nxt = '{valid: 1'b1, to_l1: 1'b0,
                    line: asc ? trig_line + PF_L2_AHEAD : trig_line - PF_L2_AHEAD};
      end else if (pf_enable[PF_L2_UPDOWN]) begin // [R20]
        req_nxt = '{valid: 1'b1, to_l1: 1'b0,
                    line: ud_r[1] ? trig_line + 42'h1 : trig_line - 42'h1};
      end
      // history update
      last_nxt    = trig_line;
      pip_nxt     = idx;
      l2_seen_nxt = asc || desc;
      l2_dir_nxt  = asc;
      if (asc && ud_r != 2'h3) begin
        ud_nxt = ud_r + 2'h1;
      end else if (desc && ud_r != 2'h0) begin
        ud_nxt = ud_r - 2'h1;
      end
      st_line_nxt[idx] = trig_line;
      st_dist_nxt[idx] = sdist;
      rg_ok_nxt[pip_r] = near && rg_d_r[pip_r] == delta[PF_RG_W-1:0];
      rg_d_nxt[pip_r]  = delta[PF_RG_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_r    <= '0;
      pip_r     <= '0;
      l2_seen_r <= 1'b0;
      l2_dir_r  <= 1'b0;
      ud_r      <= 2'h2;
      st_line_r <= '0;
      st_dist_r <= '0;
      rg_d_r    <= '0;
      rg_ok_r   <= '0;
      pf_req_r  <= '0;
    end else begin
      last_r    <= last_nxt;
      pip_r     <= pip_nxt;
      l2_seen_r <= l2_seen_nxt;
      l2_dir_r  <= l2_dir_nxt;
      ud_r      <= ud_nxt;
      st_line_r <= st_line_nxt;
      st_dist_r <= st_dist_nxt;
      rg_d_r    <= rg_d_nxt;
      rg_ok_r   <= rg_ok_nxt;
      pf_req_r  <= req_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== design/load_store_unit.sv ====
// load-store unit: issue limits, load and store queues, forwarding, misses, prefetch
// How it works
// R1 - three memory pipes, each up to 256 bits, all may issue together.
// R2 - all three may be loads, but at most two wide loads.
// R3 - at most two stores; a wide store allows only one store.
// R4 - load queue entry taken at dispatch, released on completion with data delivered.
// R5 - up to 72 loads held out of order.
// R6 - 64-entry store queue holds stores until written to the data cache.
// R7 - loads pass older loads and non-conflicting older stores; ordering stays architectural.
// R8 - older store covering every load byte with data ready forwards, any alignment.
// R9 - forwarding match uses address bits 11 down to 0 only.
// R10 - miss address buffer tracks up to 24 outstanding misses.
// R11 - simple modes: load-to-use 4 cycles integer, 7 floating point.
// R12 - complex modes add one address cycle: 5 integer, 8 floating point.
// R13 - non-zero segment base adds one cycle.
// R14 - complex mode plus segment base adds only one cycle total.
// R15 - l1 prefetchers fill both cache levels, l2 prefetchers only l2.
// R16 - l1 stream prefetcher fetches sequential lines up or down.
// R17 - l1 stride prefetcher fetches on constant per-instruction distance.
// R18 - l1 region prefetcher follows recurring nearby pattern after an instruction.
// R19 - l2 stream prefetcher fetches sequential lines up or down into l2.
// R20 - l2 up/down prefetcher picks next or previous line for every access.
// R21 - each prefetcher has its own enable.
// R22 - stores reach the cache in program order, only after commit.
`timescale 1ns/1ps
`default_nettype none
module load_store_unit
  import lsu_pkg::*;
#(
  parameter int LQ_DEPTH_P  = LQ_DEPTH,
  parameter int SQ_DEPTH_P  = SQ_DEPTH,
  parameter int MAB_DEPTH_P = MAB_DEPTH
)
(
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire mem_op_type [PIPES-1:0]       op_in,
  input  wire logic [PIPES-1:0][DATA_W-1:0] st_data,
  output logic [PIPES-1:0]                  grant_r,
  output logic [PIPES-1:0][LAT_W-1:0]       lat_r,
  output logic [PIPES-1:0]                  fwd_hit_r,
  output logic [PIPES-1:0][DATA_W-1:0]      fwd_data_r,
  input  wire logic                         ld_disp,
  input  wire logic                         ld_done,
  output logic                              lq_full_r,
  input  wire logic                         st_disp,
  input  wire logic                         st_commit,
  output logic                              sq_full_r,
  output logic [SQ_IDX_W-1:0]               sq_tail_r,
  output dc_write_type                      dc_wr_r,
  input  wire logic                         dc_wr_ready,
  input  wire logic                         miss_alloc,
  input  wire logic                         miss_fill,
  output logic                              mab_full_r,
  input  wire logic [PF_NUM-1:0]            pf_enable,
  output pf_req_type                        pf_req_r
);
  localparam int LQC_W = $clog2(LQ_DEPTH_P + 1);
  localparam int SQC_W = $clog2(SQ_DEPTH_P + 1);
  localparam int MC_W  = $clog2(MAB_DEPTH_P + 1);

  if (SQ_DEPTH_P != (1 << SQ_IDX_W) || LQ_DEPTH_P < 1 || MAB_DEPTH_P < 1) begin : g_chk
    $error("queue depths do not fit the index widths");
  end

  ////////////////////////////////////////////////////////////////////////////
  // issue limits per cycle
  logic [PIPES-1:0]            gnt;
  logic [1:0]                  wide_ld_c, st_c;
  logic                        wide_st_c;
  logic [PIPES-1:0][LAT_W-1:0] lat_c;

  always_comb begin
    gnt       = '0;
    wide_ld_c = '0;
    st_c      = '0;
    wide_st_c = 1'b0;
    for (int p = 0; p < PIPES; p++) begin // [R1]
      lat_c[p] = (op_in[p].fp ? LAT_FP_SIMPLE : LAT_INT_SIMPLE) + // [R11] [R12] [R13] [R14]
                 ((op_in[p].complex || op_in[p].seg_nz) ? LAT_EXTRA : 4'h0);
      if (op_in[p].valid && !op_in[p].is_store) begin
        if (!op_in[p].wide || wide_ld_c < 2'(MAX_WIDE_LOADS)) begin // [R2]
          gnt[p] = 1'b1;
          if (op_in[p].wide) begin
            wide_ld_c = wide_ld_c + 2'h1;
          end
        end
      end else if (op_in[p].valid) begin
        if (st_c < 2'(MAX_STORES) && !wide_st_c && !(op_in[p].wide && st_c != 2'h0)) begin // [R3]
          gnt[p]    = 1'b1;
          st_c      = st_c + 2'h1;
          wide_st_c = op_in[p].wide;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // queues and miss tracking
  sq_entry_type [SQ_DEPTH_P-1:0] sq_r, sq_nxt;
  logic [SQ_IDX_W-1:0]           head_r, head_nxt, tail_nxt;
  logic [SQC_W-1:0]              sq_cnt_r, sq_cnt_nxt, cm_cnt_r, cm_cnt_nxt;
  logic [LQC_W-1:0]              lq_cnt_r, lq_cnt_nxt;
  logic [MC_W-1:0]               mab_cnt_r, mab_cnt_nxt;
  logic                          lq_full_nxt, sq_full_nxt, mab_full_nxt;
  logic                          push, pop, commit, lq_in, lq_out, m_in, m_out;
  dc_write_type                  wr_nxt;

  always_comb begin
    sq_nxt   = sq_r;
    push     = st_disp && !sq_full_r; // [R6]
    pop      = dc_wr_r.valid && dc_wr_ready;
    commit   = st_commit && cm_cnt_r < sq_cnt_r;
    tail_nxt = push ? sq_tail_r + 6'h1 : sq_tail_r;
    head_nxt = pop ? head_r + 6'h1 : head_r;
    if (push) begin
      sq_nxt[sq_tail_r] = '{valid: 1'b1, default: '0};
    end
    for (int p = 0; p < PIPES; p++) begin
      if (gnt[p] && op_in[p].is_store) begin
        sq_nxt[op_in[p].sq_idx].addr    = op_in[p].addr;
        sq_nxt[op_in[p].sq_idx].size    = op_in[p].size;
        sq_nxt[op_in[p].sq_idx].data    = st_data[p];
        sq_nxt[op_in[p].sq_idx].addr_ok = 1'b1;
        sq_nxt[op_in[p].sq_idx].data_ok = 1'b1;
      end
    end
    if (pop) begin
      sq_nxt[head_r].valid = 1'b0; // [R6]
    end
    sq_cnt_nxt  = sq_cnt_r + SQC_W'(push) - SQC_W'(pop);
    cm_cnt_nxt  = cm_cnt_r + SQC_W'(commit) - SQC_W'(pop);
    sq_full_nxt = sq_cnt_nxt == SQC_W'(SQ_DEPTH_P);
    // oldest entry leaves only once committed, ready and not just taken
    wr_nxt = '{valid: sq_r[head_r].valid && sq_r[head_r].addr_ok && sq_r[head_r].data_ok &&
                      cm_cnt_r != '0 && !pop, // [R22]
               size: sq_r[head_r].size, addr: sq_r[head_r].addr, data: sq_r[head_r].data};
    lq_in        = ld_disp && !lq_full_r; // [R4] [R5]
    lq_out       = ld_done && lq_cnt_r != '0; // [R4]
    lq_cnt_nxt   = lq_cnt_r + LQC_W'(lq_in) - LQC_W'(lq_out);
    lq_full_nxt  = lq_cnt_nxt == LQC_W'(LQ_DEPTH_P);
    m_in         = miss_alloc && !mab_full_r; // [R10]
    m_out        = miss_fill && mab_cnt_r != '0;
    mab_cnt_nxt  = mab_cnt_r + MC_W'(m_in) - MC_W'(m_out);
    mab_full_nxt = mab_cnt_nxt == MC_W'(MAB_DEPTH_P);
  end

  ////////////////////////////////////////////////////////////////////////////
  // store-to-load forwarding per pipe
  logic [PIPES-1:0]              fwd_hit_c;
  logic [PIPES-1:0][DATA_W-1:0]  fwd_data_c;

  for (genvar p = 0; p < PIPES; p++) begin : g_fwd
    logic [SQ_IDX_W-1:0] older, e, sel;
    logic [FWD_BITS:0]   lo, hi, slo, shi, off;
    logic                hit;
    always_comb begin
      older = op_in[p].sq_idx - head_r;
      lo    = {1'b0, op_in[p].addr[FWD_BITS-1:0]}; // [R9]
      hi    = lo + 13'(op_in[p].size);
      hit   = 1'b0;
      sel   = '0;
      e     = '0;
      slo   = '0;
      shi   = '0;
      // youngest older covering store wins; loads bypass the rest [R7]
      for (int k = 0; k < SQ_DEPTH_P; k++) begin
        e   = head_r + SQ_IDX_W'(k);
        slo = {1'b0, sq_r[e].addr[FWD_BITS-1:0]}; // [R9]
        shi = slo + 13'(sq_r[e].size);
        if (SQ_IDX_W'(k) < older && sq_r[e].valid && sq_r[e].addr_ok && sq_r[e].data_ok &&
            lo >= slo && hi <= shi) begin // [R8]
          hit = 1'b1;
          sel = e;
        end
      end
      off           = lo - {1'b0, sq_r[sel].addr[FWD_BITS-1:0]};
      fwd_hit_c[p]  = hit && gnt[p] && !op_in[p].is_store;
      fwd_data_c[p] = sq_r[sel].data >> {off[4:0], 3'h0}; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prefetch trigger: oldest-pipe granted load
  logic              trig_v;
  logic [IP_W-1:0]   trig_ip;
  logic [LINE_W-1:0] trig_line;

  always_comb begin
    trig_v    = 1'b0;
    trig_ip   = '0;
    trig_line = '0;
    for (int p = PIPES - 1; p >= 0; p--) begin
      if (gnt[p] && !op_in[p].is_store) begin
        trig_v    = 1'b1;
        trig_ip   = op_in[p].ip;
        trig_line = op_in[p].addr[ADDR_W-1:LINE_LSB];
      end
    end
  end

  data_prefetcher u_pf (
    .clk        (clk),
    .arst_n     (arst_n),
    .trig_valid (trig_v),
    .trig_ip    (trig_ip),
    .trig_line  (trig_line),
    .pf_enable  (pf_enable), // [R21]
    .pf_req_r   (pf_req_r)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      grant_r    <= '0;
      lat_r      <= '0;
      fwd_hit_r  <= '0;
      fwd_data_r <= '0;
      sq_r       <= '0;
      head_r     <= '0;
      sq_tail_r  <= '0;
      sq_cnt_r   <= '0;
      cm_cnt_r   <= '0;
      sq_full_r  <= 1'b0;
      dc_wr_r    <= '0;
      lq_cnt_r   <= '0;
      lq_full_r  <= 1'b0;
      mab_cnt_r  <= '0;
      mab_full_r <= 1'b0;
    end else begin
      grant_r    <= gnt;
      lat_r      <= lat_c;
      fwd_hit_r  <= fwd_hit_c;
      fwd_data_r <= fwd_data_c;
      sq_r       <= sq_nxt;
      head_r     <= head_nxt;
      sq_tail_r  <= tail_nxt;
      sq_cnt_r   <= sq_cnt_nxt;
      cm_cnt_r   <= cm_cnt_nxt;
      sq_full_r  <= sq_full_nxt;
      dc_wr_r    <= wr_nxt;
      lq_cnt_r   <= lq_cnt_nxt;
      lq_full_r  <= lq_full_nxt;
      mab_cnt_r  <= mab_cnt_nxt;
      mab_full_r <= mab_full_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence wr_taken;
    dc_wr_r.valid && dc_wr_ready;
  endsequence

  a_three_loads_issue: assert property ( // [R1]
    (&{op_in[0].valid, op_in[1].valid, op_in[2].valid}) &&
    !(|{op_in[0].is_store, op_in[1].is_store, op_in[2].is_store, op_in[1].wide, op_in[2].wide})
    |=> grant_r == 3'h7) else $error("three narrow loads not all issued");
  a_wide_load_cap: assert property ( // [R2]
    $countones(gnt & {op_in[2].wide && !op_in[2].is_store, op_in[1].wide && !op_in[1].is_store,
                      op_in[0].wide && !op_in[0].is_store}) <= 2)
    else $error("too many wide loads");
  a_store_cap: assert property ( // [R3]
    wide_st_c |-> st_c == 2'h1) else $error("wide store issued with another store");
  a_load_release: assert property ( // [R4]
    ld_done && !ld_disp && lq_cnt_r != '0 |=> lq_cnt_r == $past(lq_cnt_r) - 1'b1)
    else $error("load queue did not release entry");
  a_lq_full_flag: assert property ( // [R5]
    lq_full_r |-> lq_cnt_r == LQC_W'(LQ_DEPTH_P)) else $error("load queue full flag wrong");
  a_lq_bound: assert property ( // [R5]
    lq_cnt_r <= LQC_W'(LQ_DEPTH_P)) else $error("load queue overfilled");
  a_sq_bound: assert property ( // [R6]
    sq_cnt_r <= SQC_W'(SQ_DEPTH_P)) else $error("store queue overfilled");
  a_sq_hold: assert property ( // [R6]
    push && !pop |=> sq_cnt_r == $past(sq_cnt_r) + 1'b1) else $error("store queue count slip");
  a_mab_bound: assert property ( // [R10]
    mab_full_r |-> mab_cnt_r == MC_W'(MAB_DEPTH_P)) else $error("miss buffer bound wrong");
  a_lat_simple_int: assert property ( // [R11]
    gnt[0] && !op_in[0].fp && !op_in[0].complex && !op_in[0].seg_nz |=> lat_r[0] == 4'h4)
    else $error("simple integer latency wrong");
  a_lat_simple_fp: assert property ( // [R11]
    gnt[1] && op_in[1].fp && !op_in[1].complex && !op_in[1].seg_nz |=> lat_r[1] == 4'h7)
    else $error("simple fp latency wrong");
  a_lat_complex_int: assert property ( // [R12]
    gnt[2] && !op_in[2].fp && op_in[2].complex |=> lat_r[2] == 4'h5)
    else $error("complex integer latency wrong");
  a_lat_seg_fp: assert property ( // [R13]
    gnt[1] && op_in[1].fp && !op_in[1].complex && op_in[1].seg_nz |=> lat_r[1] == 4'h8)
    else $error("segment base latency wrong");
  a_lat_not_additive: assert property ( // [R14]
    gnt[1] && op_in[1].fp && op_in[1].complex && op_in[1].seg_nz |=> lat_r[1] == 4'h8)
    else $error("penalties added twice");
  a_write_after_commit: assert property ( // [R22]
    dc_wr_r.valid |-> cm_cnt_r != '0) else $error("uncommitted store written");
  a_write_holds: assert property ( // [R22]
    dc_wr_r.valid && !dc_wr_ready |=> dc_wr_r.valid && $stable(dc_wr_r.addr))
    else $error("cache write dropped before taken");
  a_fwd_load_only: assert property ( // [R8]
    fwd_hit_r[0] |-> $past(gnt[0] && !op_in[0].is_store))
    else $error("forward without granted load");
  a_write_one_pop: assert property ( // [R22]
    wr_taken |=> !dc_wr_r.valid ##1 head_r == $past(head_r, 2) + 1'b1)
    else $error("store queue head did not advance once");
endmodule
`default_nettype wire

// ==== bench/dcache_model.sv ====
// data cache model that accepts store writes, promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module dcache_model
  import lsu_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire dc_write_type dc_wr,
  input  wire logic         slow,
  output logic              dc_wr_ready,
  output logic [7:0]        wr_count,
  output logic [ADDR_W-1:0] last_addr
);
  logic [1:0] ph;
  // ready changes off the sampling edge; slow mode stalls three of four cycles
  always @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph <= 2'h0;
      dc_wr_ready <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      dc_wr_ready <= !slow || (ph == 2'h3);
    end
  end
  // a write counts at the edge where valid and ready are both high
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_count <= 8'h0;
      last_addr <= '0;
    end else if (dc_wr.valid && dc_wr_ready) begin
      wr_count <= wr_count + 8'h1;
      last_addr <= dc_wr.addr;
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_load_store_unit.sv ====
// self-checking bench for the load-store unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %h got %h", nm, e, g); n_errors++; end end
module test_load_store_unit
  import lsu_pkg::*;
;
  logic                         clk;
  logic                         arst_n;
  mem_op_type [PIPES-1:0]       op;
  logic [PIPES-1:0][DATA_W-1:0] sd;
  logic [PIPES-1:0]             grant_r;
  logic [PIPES-1:0][LAT_W-1:0]  lat_r;
  logic [PIPES-1:0]             fwd_hit_r;
  logic [PIPES-1:0][DATA_W-1:0] fwd_data_r;
  logic [5:0]                   pl;
  logic                         lq_full_r;
  logic                         sq_full_r;
  logic                         mab_full_r;
  logic [SQ_IDX_W-1:0]          sq_tail_r;
  dc_write_type                 dc_wr_r;
  logic                         rdy;
  logic                         slow;
  logic [7:0]                   wcnt;
  logic [ADDR_W-1:0]            waddr;
  logic [PF_NUM-1:0]            pf_en;
  pf_req_type                   pf_req_r;
  int                           n_errors;
  int                           n_tests;
  int                           pf_seen;
  logic                         pf_l1;
  logic [LINE_W-1:0]            pf_ln;
  load_store_unit uut (.clk(clk), .arst_n(arst_n), .op_in(op), .st_data(sd),
    .grant_r(grant_r), .lat_r(lat_r), .fwd_hit_r(fwd_hit_r), .fwd_data_r(fwd_data_r),
    .ld_disp(pl[0]), .ld_done(pl[1]), .lq_full_r(lq_full_r), .st_disp(pl[4]),
    .st_commit(pl[5]), .sq_full_r(sq_full_r), .sq_tail_r(sq_tail_r), .dc_wr_r(dc_wr_r),
    .dc_wr_ready(rdy), .miss_alloc(pl[2]), .miss_fill(pl[3]), .mab_full_r(mab_full_r),
    .pf_enable(pf_en), .pf_req_r(pf_req_r));
  dcache_model cache (.clk(clk), .arst_n(arst_n), .dc_wr(dc_wr_r), .slow(slow),
    .dc_wr_ready(rdy), .wr_count(wcnt), .last_addr(waddr));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (pf_req_r.valid === 1'b1) begin
      pf_seen++;
      pf_l1 = pf_req_r.to_l1;
      pf_ln = pf_req_r.line;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic mem_op_type mk(input logic s, w, f, c, g, input int i, z,
                                    input logic [47:0] a);
    mk = '0;
    mk.valid = 1'b1;
    mk.is_store = s;
    mk.wide = w;
    mk.fp = f;
    mk.complex = c;
    mk.seg_nz = g;
    mk.sq_idx = SQ_IDX_W'(i);
    mk.size = SZ_W'(z);
    mk.addr = a;
  endfunction
  function automatic logic flag(input int w);
    flag = (w == 0) ? lq_full_r : (w == 2) ? mab_full_r : sq_full_r;
  endfunction
  // one issue cycle, registered grant checked at the next falling edge, after the ops are cleared
  task automatic issue(input mem_op_type a, b, c, input logic [2:0] eg);
    @(negedge clk);
    op = {c, b, a};
    @(negedge clk);
    op = '0;
    `CHK("grant", eg, grant_r)
  endtask
  task automatic pulse(input int w, input int n);
    @(negedge clk);
    pl[w] = 1'b1;
    repeat (n - 1) @(negedge clk);
    @(negedge clk);
    pl[w] = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_cnt(input int wi, input int wo, input int d);
    pulse(wi, d - 1);
    `CHK("full_below", 1'b0, flag(wi))
    pulse(wi, 2);
    `CHK("full_at", 1'b1, flag(wi))
    if (wo >= 0) begin
      pulse(wo, 1);
      `CHK("full_freed", 1'b0, flag(wi))
    end
  endtask
  task automatic t_lat();
    mem_op_type m;
    logic [3:0] x;
    for (int k = 0; k < 8; k++) begin
      m = mk(0, 0, k[0], k[1], k[2], 0, 8, 48'h40);
      x = (k[0] ? 4'h7 : 4'h4) + ((k[1] | k[2]) ? 4'h1 : 4'h0);
      issue('0, m, m, 3'h6);
      `CHK("lat", x, lat_r[1])
      `CHK("lat_p2", x, lat_r[2])
    end
  endtask
  task automatic t_ld_lim();
    issue(mk(0, 0, 0, 0, 0, 0, 4, 48'h0), mk(0, 0, 0, 0, 0, 0, 4, 48'h8),
          mk(0, 0, 0, 0, 0, 0, 4, 48'h10), 3'h7);
    issue(mk(0, 1, 1, 0, 0, 0, 32, 48'h0), mk(0, 1, 1, 0, 0, 0, 16, 48'h40),
          mk(0, 1, 1, 0, 0, 0, 32, 48'h80), 3'h3);
    issue(mk(0, 0, 0, 0, 0, 0, 8, 48'h0), mk(0, 1, 1, 0, 0, 0, 32, 48'h40),
          mk(0, 1, 1, 0, 0, 0, 32, 48'h80), 3'h7);
  endtask
  task automatic t_fwd();
    pulse(4, 2);
    `CHK("tail", 6'h02, sq_tail_r)
    sd = '0;
    sd[0][63:0] = 64'h1817161514131211;
    issue(mk(1, 0, 0, 0, 0, 0, 8, 48'h100), '0, '0, 3'h1);
    sd[0][63:0] = 64'h2827262524232221;
    issue(mk(1, 0, 0, 0, 0, 1, 8, 48'h200), '0, '0, 3'h1);
    issue(mk(0, 0, 0, 0, 0, 2, 4, 48'h102), mk(0, 0, 0, 0, 0, 2, 4, 48'h0010_0000_0102),
          mk(0, 0, 0, 0, 0, 2, 4, 48'h106), 3'h7);
    `CHK("fwd_hit", 3'h3, fwd_hit_r)
    `CHK("fwd_data", 32'h16151413, fwd_data_r[0][31:0])
    `CHK("fwd_alias", 32'h16151413, fwd_data_r[1][31:0])
    issue(mk(0, 0, 0, 0, 0, 0, 4, 48'h102), '0, '0, 3'h1);
    `CHK("fwd_young", 1'b0, fwd_hit_r[0])
    repeat (4) @(negedge clk);
    `CHK("no_write", 8'h0, wcnt)
    slow = 1'b1;
    pulse(5, 2);
    for (int n = 1; n <= 2; n++) begin
      for (int t = 0; t < 40 && wcnt < 8'(n); t++) @(negedge clk);
      `CHK("wr_addr", (n == 1) ? 48'h100 : 48'h200, waddr)
    end
    repeat (6) @(negedge clk);
    `CHK("wr_total", 8'h2, wcnt)
    slow = 1'b0;
  endtask
  task automatic t_pf(input logic [PF_NUM-1:0] en, input logic l1, input logic [LINE_W-1:0] ln);
    pf_en = en;
    pf_seen = 0;
    for (int k = 0; k < 6; k++) issue(mk(0, 0, 0, 0, 0, 0, 8, 48'(k) << 6), '0, '0, 3'h1);
    repeat (3) @(negedge clk);
    `CHK("pf_fires", en != '0, pf_seen > 0)
    if (en != '0) begin
      `CHK("pf_level", l1, pf_l1)
      `CHK("pf_line", ln, pf_ln)
    end
  endtask
  task automatic t_st_lim();
    issue(mk(1, 0, 0, 0, 0, 2, 8, 48'h0), mk(1, 0, 0, 0, 0, 3, 8, 48'h8),
          mk(0, 0, 0, 0, 0, 0, 8, 48'h40), 3'h7);
    issue(mk(1, 1, 1, 0, 0, 4, 32, 48'h0), mk(1, 0, 0, 0, 0, 5, 8, 48'h40),
          mk(0, 0, 0, 0, 0, 0, 8, 48'h80), 3'h5);
    issue(mk(1, 0, 0, 0, 0, 6, 8, 48'h0), mk(1, 1, 1, 0, 0, 7, 32, 48'h40),
          mk(0, 0, 0, 0, 0, 0, 8, 48'h80), 3'h5);
    issue(mk(1, 0, 0, 0, 0, 8, 8, 48'h0), mk(1, 0, 0, 0, 0, 9, 8, 48'h40),
          mk(1, 0, 0, 0, 0, 10, 8, 48'h80), 3'h3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    n_errors = 0;
    n_tests = 0;
    arst_n = 1'b0;
    op = '0;
    sd = '0;
    pl = '0;
    slow = 1'b0;
    pf_en = '0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    `CHK("rst_out", 3'h0, {lq_full_r, sq_full_r, grant_r[0]})
    t_lat();
    t_ld_lim();
    t_fwd();
    t_cnt(0, 1, LQ_DEPTH);
    t_cnt(2, 3, MAB_DEPTH);
    t_pf(5'h00, 1'b0, 42'h0);
    t_pf(5'h10, 1'b0, 42'h6);
    t_pf(5'h01, 1'b1, 42'h6);
    t_pf(5'h02, 1'b1, 42'h6);
    t_pf(5'h04, 1'b1, 42'h6);
    t_pf(5'h08, 1'b0, 42'h5 + PF_L2_AHEAD);
    t_cnt(4, -1, SQ_DEPTH);
    `CHK("tail_wrap", 6'h02, sq_tail_r)
    t_st_lim();
    report_and_stop();
  end
  initial begin
    #(20 * 5000);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
